// ### hdl/spg_pkg.sv
// Constants shared by the spanning tree port gating block.
// Assumes a 16-bit register port with byte offsets on word addresses.
package spg_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PORT1_CONTROL_TWO_OFS           = 8'h00;
    localparam logic [7:0] PORT2_CONTROL_TWO_OFS           = 8'h04;
    localparam logic [7:0] SWITCH_GLOBAL_CONTROL_EIGHT_OFS = 8'h08;
    localparam logic [7:0] PORT_STATE_STATUS_OFS           = 8'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LEARN_DIS_BIT = 0;
    localparam int RX_EN_BIT     = 1;
    localparam int TX_EN_BIT     = 2;
    localparam int FLUSH_LO_BIT  = 9;
    localparam int FLUSH_HI_BIT  = 10;
    localparam int STAT_P1_LO    = 0;
    localparam int STAT_P2_LO    = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PORT_CONTROL_TWO_RST = 16'h0006;
    localparam logic [15:0] GLOBAL_EIGHT_RST     = 16'h0000;

    // ------------------------------------------------------------
    // Port codes and effective port states
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_PORT1 = 2'h1;
    localparam logic [1:0] SRC_PORT2 = 2'h2;
    localparam logic [1:0] SRC_HOST  = 2'h3;

    typedef enum logic [1:0] {
        SPG_DISCARD,
        SPG_LEARN,
        SPG_FORWARD,
        SPG_ODD
    } spg_state_t;

endpackage

// ### hdl/spg_port_gate.sv
// One network port's gating controls, applied at frame boundaries.
// Assumes busy flags from the port MAC on the same clock.
`timescale 1ns/1ps

module spg_port_gate (
    // Clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              resetn_in,
    // Requested controls: tx enable, rx enable, learning disable
    input  wire logic [2:0]        ctrl_in,
    // Frame activity
    input  wire logic              rx_busy_in,
    input  wire logic              tx_busy_in,
    // Effective controls
    output logic                   tx_en_out,
    output logic                   rx_en_out,
    output logic                   learn_dis_out,
    output spg_pkg::spg_state_t    state_out
);

    logic                 boundary;
    spg_pkg::spg_state_t  state_nxt;

    // ------------------------------------------------------------
    // Boundary detect and state decode
    // ------------------------------------------------------------
    // Change only between frames so nothing is cut short
    assign boundary = !rx_busy_in && !tx_busy_in;

    // Decode the five classic states into three rapid ones
    always_comb begin
        case (ctrl_in)
            3'b001:  state_nxt = spg_pkg::SPG_DISCARD;
            3'b000:  state_nxt = spg_pkg::SPG_LEARN;
            3'b110:  state_nxt = spg_pkg::SPG_FORWARD;
            default: state_nxt = spg_pkg::SPG_ODD;
        endcase
    end

    // ------------------------------------------------------------
    // Effective control registers
    // ------------------------------------------------------------
    // Held while a frame is in flight on either direction
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            tx_en_out     <= spg_pkg::PORT_CONTROL_TWO_RST[spg_pkg::TX_EN_BIT];
            rx_en_out     <= spg_pkg::PORT_CONTROL_TWO_RST[spg_pkg::RX_EN_BIT];
            learn_dis_out <=
                spg_pkg::PORT_CONTROL_TWO_RST[spg_pkg::LEARN_DIS_BIT];
            state_out     <= spg_pkg::SPG_FORWARD;
        end else if (boundary) begin
            tx_en_out     <= ctrl_in[2];
            rx_en_out     <= ctrl_in[1];
            learn_dis_out <= ctrl_in[0];
            state_out     <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_discard_code: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        boundary && ctrl_in == 3'b001 |=>
            state_out == spg_pkg::SPG_DISCARD && learn_dis_out
            && !tx_en_out && !rx_en_out)
        else $error("discard setting not decoded");

endmodule

// ### hdl/spg_top.sv
// Spanning tree gating for the two network ports of a three-port switch.
// Assumes lookup results, MAC busy flags and register strobes share
// sys_clk_in; the host port is port code 3 and mask bit 2.
//
// Overview of operation
// - Each network port has transmit enable, receive enable and learning disable that pick its tree state.
// - The host port is the processor's designated port and is never gated.
// - Transmit 0, receive 0, learning disable 1 passes no user traffic, only override frames to the processor.
// - With learning disable set no source address is learned from that port.
// - Transmit 0, receive 0, learning disable 0 learns addresses but passes only processor traffic.
// - Transmit 1, receive 1, learning disable 0 forwards, receives and learns normally.
// - Static entries with the override bit go to the processor even when receive is off.
// - Frames the processor directs to a port are sent there even with transmit enable 0.
// - With learning disabled, the flush field of the global register flushes that port's entries.
// - The rapid discarding state uses transmit 0, receive 0, learning disable 1.
`timescale 1ns/1ps

module spg_top (
    // Clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              resetn_in,
    // Register port
    input  wire logic [7:0]        reg_addr_in,
    input  wire logic [15:0]       reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic [15:0]            reg_rdata_out,
    // Port MAC activity
    input  wire logic              p1_rx_busy_in,
    input  wire logic              p1_tx_busy_in,
    input  wire logic              p2_rx_busy_in,
    input  wire logic              p2_tx_busy_in,
    // Lookup result for one frame
    input  wire logic              lk_valid_in,
    input  wire logic [1:0]        lk_src_port_in,
    input  wire logic [2:0]        lk_dest_mask_in,
    input  wire logic              lk_override_in,
    input  wire logic [1:0]        lk_tail_tag_in,
    // Gated forwarding decision
    output logic                   fw_valid_out,
    output logic [2:0]             fw_mask_out,
    output logic                   fw_learn_out,
    // Address table flush request
    output logic                   flush_valid_out,
    output logic [1:0]             flush_port_out,
    // Effective port states
    output spg_pkg::spg_state_t    p1_state_out,
    output spg_pkg::spg_state_t    p2_state_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [15:0] port1_control_two_r;
    logic [15:0] port2_control_two_r;
    logic [15:0] switch_global_control_eight_r;
    logic [15:0] rdata_nxt;
    logic        p1_tx_en;
    logic        p1_rx_en;
    logic        p1_ld;
    logic        p2_tx_en;
    logic        p2_rx_en;
    logic        p2_ld;
    logic        wr_p1;
    logic        wr_p2;
    logic        wr_glob;
    logic [1:0]  flush_nxt;
    logic [1:0]  p1_fwd;
    logic [1:0]  p2_fwd;
    logic [2:0]  mask_nxt;
    logic        learn_nxt;
    logic [15:0] status_word;

    // Gating for a frame received on a network port: {host, other port}
    function automatic logic [1:0] net_fwd(
        input logic       rx_en,
        input logic       other_tx_en,
        input logic       override,
        input logic [1:0] dest
    );
        logic [1:0] res;
        res = 2'b00;
        if (rx_en) begin
            // Host leg is never gated; the other port follows its tx
            res = {dest[1], dest[0] & other_tx_en};
        end
        // Override frames reach the processor even with rx off
        if (override) begin
            res[1] = 1'b1;
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    assign wr_p1   = reg_wr_in && reg_addr_in == spg_pkg::PORT1_CONTROL_TWO_OFS;
    assign wr_p2   = reg_wr_in && reg_addr_in == spg_pkg::PORT2_CONTROL_TWO_OFS;
    assign wr_glob = reg_wr_in
        && reg_addr_in == spg_pkg::SWITCH_GLOBAL_CONTROL_EIGHT_OFS;

    // Flush only ports whose learning is really off now
    assign flush_nxt = wr_glob ?
        (reg_wdata_in[spg_pkg::FLUSH_HI_BIT:spg_pkg::FLUSH_LO_BIT]
         & {p2_ld, p1_ld}) : 2'b00;

    // Live state as applied, not as last written
    assign status_word = {8'h00,
        2'b00, p2_state_out, 2'b00, p1_state_out};

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                spg_pkg::PORT1_CONTROL_TWO_OFS:
                    rdata_nxt = port1_control_two_r;
                spg_pkg::PORT2_CONTROL_TWO_OFS:
                    rdata_nxt = port2_control_two_r;
                spg_pkg::SWITCH_GLOBAL_CONTROL_EIGHT_OFS:
                    rdata_nxt = switch_global_control_eight_r;
                spg_pkg::PORT_STATE_STATUS_OFS:
                    rdata_nxt = status_word;
                default:
                    rdata_nxt = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    // Only the three control bits exist; the rest read as zero
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            port1_control_two_r <= spg_pkg::PORT_CONTROL_TWO_RST;
            port2_control_two_r <= spg_pkg::PORT_CONTROL_TWO_RST;
        end else begin
            if (wr_p1) begin
                port1_control_two_r <= {13'h0000, reg_wdata_in[2:0]};
            end
            if (wr_p2) begin
                port2_control_two_r <= {13'h0000, reg_wdata_in[2:0]};
            end
        end
    end

    // Flush bits are self-clearing, so they never read back as set
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            switch_global_control_eight_r <= spg_pkg::GLOBAL_EIGHT_RST;
        end else if (wr_glob) begin
            switch_global_control_eight_r <= reg_wdata_in & 16'hf9ff;
        end
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 16'h0000;
        end else begin
            reg_rdata_out <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Per-port gates
    // ------------------------------------------------------------
    spg_port_gate u_gate1 (
        .sys_clk_in    (sys_clk_in),
        .resetn_in     (resetn_in),
        .ctrl_in       (port1_control_two_r[2:0]),
        .rx_busy_in    (p1_rx_busy_in),
        .tx_busy_in    (p1_tx_busy_in),
        .tx_en_out     (p1_tx_en),
        .rx_en_out     (p1_rx_en),
        .learn_dis_out (p1_ld),
        .state_out     (p1_state_out)
    );

    spg_port_gate u_gate2 (
        .sys_clk_in    (sys_clk_in),
        .resetn_in     (resetn_in),
        .ctrl_in       (port2_control_two_r[2:0]),
        .rx_busy_in    (p2_rx_busy_in),
        .tx_busy_in    (p2_tx_busy_in),
        .tx_en_out     (p2_tx_en),
        .rx_en_out     (p2_rx_en),
        .learn_dis_out (p2_ld),
        .state_out     (p2_state_out)
    );

    // ------------------------------------------------------------
    // Forwarding decision
    // ------------------------------------------------------------
    // Rx off drops all but override frames to the host
    assign p1_fwd = net_fwd(p1_rx_en, p2_tx_en, lk_override_in,
                            {lk_dest_mask_in[2], lk_dest_mask_in[1]});
    assign p2_fwd = net_fwd(p2_rx_en, p1_tx_en, lk_override_in,
                            {lk_dest_mask_in[2], lk_dest_mask_in[0]});

    // Host frames: a trailer steers past tx enable
    always_comb begin
        mask_nxt  = 3'b000;
        learn_nxt = 1'b0;
        case (lk_src_port_in)
            spg_pkg::SRC_PORT1: begin
                mask_nxt  = {p1_fwd[1], p1_fwd[0], 1'b0};
                learn_nxt = !p1_ld;
            end
            spg_pkg::SRC_PORT2: begin
                mask_nxt  = {p2_fwd[1], 1'b0, p2_fwd[0]};
                learn_nxt = !p2_ld;
            end
            spg_pkg::SRC_HOST: begin
                learn_nxt = 1'b1;
                if (lk_tail_tag_in != 2'b00) begin
                    mask_nxt = {1'b0, lk_tail_tag_in[1], lk_tail_tag_in[0]};
                end else begin
                    mask_nxt = {1'b0, lk_dest_mask_in[1] & p2_tx_en,
                                lk_dest_mask_in[0] & p1_tx_en};
                end
            end
            default: begin
                mask_nxt  = 3'b000;
                learn_nxt = 1'b0;
            end
        endcase
    end

    // Decision and flush outputs, one cycle after the request
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            fw_valid_out    <= 1'b0;
            fw_mask_out     <= 3'b000;
            fw_learn_out    <= 1'b0;
            flush_valid_out <= 1'b0;
            flush_port_out  <= 2'b00;
        end else begin
            fw_valid_out    <= lk_valid_in;
            fw_mask_out     <= lk_valid_in ? mask_nxt : 3'b000;
            fw_learn_out    <= lk_valid_in && learn_nxt;
            flush_valid_out <= |flush_nxt;
            flush_port_out  <= flush_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_blocked_no_user: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        lk_valid_in && lk_src_port_in == spg_pkg::SRC_PORT1 && !p1_rx_en
        && !lk_override_in |=> fw_valid_out && fw_mask_out == 3'b000)
        else $error("blocked port passed a frame");

    chk_override_to_host: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        lk_valid_in && lk_src_port_in == spg_pkg::SRC_PORT1 && !p1_rx_en
        && lk_override_in |=> fw_mask_out == 3'b100)
        else $error("override frame not sent to host only");

    chk_learn_off: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        lk_valid_in && lk_src_port_in == spg_pkg::SRC_PORT1 && p1_ld
        |=> fw_valid_out && !fw_learn_out)
        else $error("learned with learning disabled");

    chk_learn_on: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        lk_valid_in && lk_src_port_in == spg_pkg::SRC_PORT2 && !p2_ld
        |=> fw_learn_out)
        else $error("learning enabled port did not learn");

    chk_fwd_normal: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        lk_valid_in && lk_src_port_in == spg_pkg::SRC_PORT1 && p1_rx_en
        && p2_tx_en && lk_dest_mask_in[1] |=> fw_mask_out[1])
        else $error("forwarding port dropped a frame");

    chk_directed_send: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        lk_valid_in && lk_src_port_in == spg_pkg::SRC_HOST
        && lk_tail_tag_in == 2'b01 |=> fw_mask_out == 3'b001)
        else $error("directed frame not sent to port 1");

    chk_host_ungated: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        lk_valid_in && lk_src_port_in == spg_pkg::SRC_PORT2 && p2_rx_en
        && lk_dest_mask_in[2] |=> fw_mask_out[2])
        else $error("host leg was gated");

    chk_flush_pulse: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        wr_glob && reg_wdata_in[spg_pkg::FLUSH_LO_BIT] && p1_ld
        |=> flush_valid_out && flush_port_out[0] ##1 !flush_valid_out)
        else $error("flush not issued for port 1");

    chk_state_at_boundary: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        p1_rx_busy_in || p1_tx_busy_in |=> $stable(p1_state_out)
        && $stable(p1_tx_en) && $stable(p1_rx_en))
        else $error("port 1 controls changed mid-frame");

endmodule

// ### test/spg_host_model.sv
// Host processor model sitting on the switch host port.
// Assumes lookup and forwarding signals share sys_clk_in.
`timescale 1ns/1ps

module spg_host_model (
    // Clock
    input  wire logic                sys_clk_in,
    // Send request from the bench
    input  wire logic                send_in,
    input  wire logic [1:0]          tag_in,
    // Switch side view
    input  wire logic                lk_valid_in,
    input  wire logic [1:0]          lk_src_port_in,
    input  wire logic                fw_valid_in,
    input  wire logic [2:0]          fw_mask_in,
    input  wire spg_pkg::spg_state_t p1_state_in,
    input  wire spg_pkg::spg_state_t p2_state_in,
    // Frames handed to the switch
    output logic                     lk_valid_out,
    output logic [1:0]               lk_tail_tag_out,
    // Delivered frames thrown away by software
    output logic [7:0]               dropped_out
);
    logic [1:0] src_r;

    // Port shut: disabled, blocking or discarding share one setting
    wire p1_shut = (p1_state_in == spg_pkg::SPG_DISCARD);
    wire p2_shut = (p2_state_in == spg_pkg::SPG_DISCARD);
    // Software never aims a trailer at a shut port
    wire refuse = (tag_in[0] & p1_shut) | (tag_in[1] & p2_shut);
    // Override frames still arriving from a shut port are discarded
    wire drop = fw_valid_in & fw_mask_in[2]
        & ((src_r == spg_pkg::SRC_PORT1 & p1_shut)
        | (src_r == spg_pkg::SRC_PORT2 & p2_shut));

    initial begin
        lk_valid_out = 1'b0;
        lk_tail_tag_out = 2'h0;
        dropped_out = 8'h00;
        src_r = 2'h0;
    end

    // Send with trailer; source remembered for the answer next cycle
    always @(posedge sys_clk_in) begin
        lk_valid_out <= send_in & ~refuse;
        lk_tail_tag_out <= send_in ? tag_in : 2'h0;
        if (lk_valid_in) begin
            src_r <= lk_src_port_in;
        end
        if (drop) begin
            dropped_out <= dropped_out + 8'h01;
        end
    end
endmodule

// ### test/test_spanning_tree_port_gating.sv
// Self-checking bench for the spanning tree port gating block.
// Assumes the host model drives host frames; bench drives the rest.
`timescale 1ns/1ps

module test_spanning_tree_port_gating;
    logic clk;
    logic resetn;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] rdata;
    logic p1_rxb, p1_txb, p2_rxb, p2_txb;
    logic tb_lk, ovr, send, h_lk;
    logic [1:0] src, tag, h_tag;
    logic [2:0] dest, fw_mask;
    logic fw_valid, fw_learn, fl_valid;
    logic [1:0] fl_port;
    logic [7:0] dropped;
    spg_pkg::spg_state_t p1_st, p2_st;
    int num_errors = 0;
    int compares = 0;

    // ----------------------------------------------------------------
    // Design and host model
    // ----------------------------------------------------------------
    spg_top spg_top_inst (.sys_clk_in(clk), .resetn_in(resetn),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
        .p1_rx_busy_in(p1_rxb), .p1_tx_busy_in(p1_txb),
        .p2_rx_busy_in(p2_rxb), .p2_tx_busy_in(p2_txb),
        .lk_valid_in(tb_lk | h_lk),
        .lk_src_port_in(h_lk ? spg_pkg::SRC_HOST : src),
        .lk_dest_mask_in(dest), .lk_override_in(ovr),
        .lk_tail_tag_in(h_tag), .fw_valid_out(fw_valid),
        .fw_mask_out(fw_mask), .fw_learn_out(fw_learn),
        .flush_valid_out(fl_valid), .flush_port_out(fl_port),
        .p1_state_out(p1_st), .p2_state_out(p2_st));

    spg_host_model spg_host_model_inst (.sys_clk_in(clk), .send_in(send),
        .tag_in(tag), .lk_valid_in(tb_lk | h_lk),
        .lk_src_port_in(h_lk ? spg_pkg::SRC_HOST : src),
        .fw_valid_in(fw_valid), .fw_mask_in(fw_mask), .p1_state_in(p1_st),
        .p2_state_in(p2_st), .lk_valid_out(h_lk),
        .lk_tail_tag_out(h_tag), .dropped_out(dropped));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Compare and count; four-state match so unknowns never pass
    task automatic check(input string n, input logic [15:0] g,
                         input logic [15:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    task automatic end_sim;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        {reg_wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        {reg_rd, addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", rdata, e);
    endtask

    // Network frame lookup; answer exactly one cycle later
    task automatic net(input logic [1:0] s, input logic [2:0] d,
                       input logic o, input logic [2:0] m, input logic l);
        @(posedge clk);
        {tb_lk, src, dest, ovr} <= {1'b1, s, d, o};
        @(posedge clk);
        {tb_lk, ovr} <= 2'h0;
        #1;
        check("fw_valid", {15'h0, fw_valid}, 16'h0001);
        check("fw_mask", {13'h0, fw_mask}, {13'h0, m});
        check("fw_learn", {15'h0, fw_learn}, {15'h0, l});
    endtask

    // Host frame through the model; host source always learns
    task automatic hs(input logic [1:0] t, input logic [2:0] d,
                      input logic [2:0] m);
        @(posedge clk);
        {send, tag, dest} <= {1'b1, t, d};
        @(posedge clk);
        send <= 1'b0;
        @(posedge clk);
        #1;
        check("fw_valid", {15'h0, fw_valid}, 16'h0001);
        check("fw_mask", {13'h0, fw_mask}, {13'h0, m});
        check("fw_learn", {15'h0, fw_learn}, 16'h0001);
    endtask

    // Bounded wait for a port state to settle
    task automatic wst(input logic p2, input spg_pkg::spg_state_t e);
        int n;
        n = 0;
        while (n < 10 && (p2 ? p2_st : p1_st) !== e) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("port_state", {14'h0, p2 ? p2_st : p1_st}, {14'h0, e});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd(8'h00, 16'h0006);
        rd(8'h04, 16'h0006);
        rd(8'h08, 16'h0000);
        rd(8'h0c, 16'h0022);
        rd(8'h10, 16'h0000);
        $display("test reset done");
    endtask

    // Discard entered only after the frame in flight ends
    task automatic t_discard;
        @(posedge clk);
        p1_rxb <= 1'b1;
        wr(8'h00, 16'h0001);
        repeat (6) @(posedge clk);
        #1;
        check("p1_state", {14'h0, p1_st}, 16'h0002);
        @(posedge clk);
        p1_rxb <= 1'b0;
        wst(1'b0, spg_pkg::SPG_DISCARD);
        net(2'h2, 3'h1, 1'b0, 3'h0, 1'b1);
        net(2'h1, 3'h2, 1'b0, 3'h0, 1'b0);
        net(2'h1, 3'h4, 1'b0, 3'h0, 1'b0);
        net(2'h1, 3'h6, 1'b1, 3'h4, 1'b0);
        @(posedge clk);
        #1;
        check("dropped", {8'h00, dropped}, 16'h0001);
        check("fw_valid", {15'h0, fw_valid}, 16'h0000);
        wr(8'h08, 16'h0600);
        #1;
        check("flush_valid", {15'h0, fl_valid}, 16'h0001);
        check("flush_port", {14'h0, fl_port}, 16'h0001);
        rd(8'h08, 16'h0000);
        $display("test discard done");
    endtask

    task automatic t_learn;
        wr(8'h00, 16'h0000);
        wst(1'b0, spg_pkg::SPG_LEARN);
        net(2'h1, 3'h2, 1'b0, 3'h0, 1'b1);
        hs(2'h1, 3'h0, 3'h1);
        hs(2'h0, 3'h1, 3'h0);
        hs(2'h3, 3'h0, 3'h3);
        hs(2'h2, 3'h0, 3'h2);
        net(2'h2, 3'h4, 1'b0, 3'h4, 1'b1);
        wr(8'h08, 16'h0200);
        #1;
        check("flush_valid", {15'h0, fl_valid}, 16'h0000);
        $display("test learn done");
    endtask

    task automatic t_forward;
        wr(8'h00, 16'h0006);
        wst(1'b0, spg_pkg::SPG_FORWARD);
        net(2'h1, 3'h2, 1'b0, 3'h2, 1'b1);
        net(2'h2, 3'h1, 1'b0, 3'h1, 1'b1);
        wr(8'h04, 16'h0001);
        wst(1'b1, spg_pkg::SPG_DISCARD);
        rd(8'h0c, 16'h0002);
        wr(8'h08, 16'h0400);
        #1;
        check("flush_port", {14'h0, fl_port}, 16'h0002);
        $display("test forward done");
    endtask

    // ----------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {resetn, reg_wr, reg_rd, tb_lk, ovr, send} = 6'h00;
        {addr, wdata, src, tag, dest} = 31'h0;
        {p1_rxb, p1_txb, p2_rxb, p2_txb} = 4'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_discard();
        t_learn();
        t_forward();
        end_sim();
    end

    // Whole run needs under a hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        $display("watchdog expired");
        end_sim();
    end
endmodule
